/* src/vbc_band_search.sv */
// Linear or mixed search over VCO bands, timed by the calibration tick
`timescale 1ns/1ps
`default_nettype none
`include "vbc_defs.svh"

module vbc_band_search (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Control
  input wire logic start_i,
  input wire logic mixed_i,
  input wire logic [11:0] dwell_i,
  input wire logic tick_i,
  input wire logic vco_slow_i,
  // Results
  output vbc_pkg::vbc_band_t band_o,
  output logic busy_o,
  output logic done_o
);

  vbc_pkg::vbc_state_t state, next_state; // Sequencer
  vbc_pkg::vbc_band_t next_band;
  logic [5:0] step, next_step; // Current stride
  logic dir_up, next_dir_up; // Last linear direction
  logic first, next_first; // No linear step taken yet
  logic [11:0] cnt, next_cnt; // Ticks in this trial
  logic next_done;

  // ----------------------------------------------------------------------
  // Next state; a new start always restarts the search
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_band = band_o;
    next_step = step;
    next_dir_up = dir_up;
    next_first = first;
    next_cnt = cnt;
    next_done = 1'b0;
    if (start_i) begin
      next_state = vbc_pkg::VBC_DWELL;
      next_cnt = 12'h000;
      next_first = 1'b1;
      // Mixed begins mid range with a wide stride
      next_band = mixed_i ? `VBC_BAND_MID : band_o;
      next_step = mixed_i ? `VBC_MIXED_STEP : 6'h01;
    end else begin
      unique case (state)
        vbc_pkg::VBC_IDLE: begin
          next_state = vbc_pkg::VBC_IDLE;
        end
        vbc_pkg::VBC_DWELL: begin
          // Trial length counted in timebase ticks
          if (tick_i) begin
            if (cnt + 12'h001 >= dwell_i) begin
              next_cnt = 12'h000;
              next_state = vbc_pkg::VBC_DECIDE;
            end else begin
              next_cnt = cnt + 12'h001;
            end
          end
        end
        vbc_pkg::VBC_DECIDE: begin
          next_state = vbc_pkg::VBC_DWELL;
          if (step != 6'h01) begin
            // Halving phase, then linear finish
            next_band = vco_slow_i ? band_o + step : band_o - step;
            next_step = step >> 1;
          end else if ((!first && (vco_slow_i != dir_up)) ||
                       (vco_slow_i && band_o == `VBC_BAND_MAX) ||
                       (!vco_slow_i && band_o == 6'h00)) begin
            // Direction flipped or range end: band found
            next_state = vbc_pkg::VBC_IDLE;
            next_done = 1'b1;
          end else begin
            // One band at a time
            next_band = vco_slow_i ? band_o + 6'h01 : band_o - 6'h01;
            next_dir_up = vco_slow_i;
            next_first = 1'b0;
          end
        end
        default: next_state = vbc_pkg::VBC_IDLE;
      endcase
    end
  end

  assign busy_o = (state != vbc_pkg::VBC_IDLE);

  // Registers only
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= vbc_pkg::VBC_IDLE;
      band_o <= `VBC_RST_BAND;
      step <= 6'h01;
      dir_up <= 1'b0;
      first <= 1'b1;
      cnt <= 12'h000;
      done_o <= 1'b0;
    end else begin
      state <= next_state;
      band_o <= next_band;
      step <= next_step;
      dir_up <= next_dir_up;
      first <= next_first;
      cnt <= next_cnt;
      done_o <= next_done;
    end
  end

endmodule : vbc_band_search
`default_nettype wire

/* src/vbc_defs.svh */
// Offsets, field positions, reset values and counts of the band calibration block
`ifndef VBC_DEFS_SVH
`define VBC_DEFS_SVH

// ----------------------------------------------------------------------
// Word addresses on the register port
// ----------------------------------------------------------------------
`define VBC_ADDR_FREQ 4'h0
`define VBC_ADDR_STAT 4'h1
`define VBC_ADDR_W6 4'h6
`define VBC_ADDR_W7 4'h7
`define VBC_ADDR_W8 4'h8
`define VBC_ADDR_W9 4'h9
`define VBC_ADDR_W12 4'hc

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define VBC_FREQ_MSB 15
`define VBC_MODE_MSB 2
`define VBC_MODE_LSB 0
`define VBC_BIAS_MSB 7
`define VBC_BIAS_LSB 4
`define VBC_SCALE_MSB 21
`define VBC_SCALE_LSB 10
`define VBC_ADJ_BIT 4
`define VBC_DIV_MSB 1
`define VBC_DIV_LSB 0
`define VBC_METH_MSB 1
`define VBC_METH_LSB 0
`define VBC_ST_BUSY 0
`define VBC_ST_DONE 1
`define VBC_ST_ERR 2
`define VBC_ST_BAND_MSB 13
`define VBC_ST_BAND_LSB 8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define VBC_RST_FREQ 16'h0000
`define VBC_RST_MODE 3'h0
`define VBC_RST_BIAS 4'h8
`define VBC_RST_SCALE 12'h000
`define VBC_RST_DIV 2'h1
`define VBC_RST_METH 2'h1
`define VBC_RST_FIXED 32'h0000_0000
`define VBC_RST_BAND 6'h20

// ----------------------------------------------------------------------
// Codes and counts
// ----------------------------------------------------------------------
`define VBC_MODE_MANUAL 3'h4
`define VBC_METH_LINEAR 2'h1
`define VBC_METH_MIXED 2'h2
`define VBC_BAND_MID 6'h20
`define VBC_BAND_MAX 6'h3f
`define VBC_MIXED_STEP 6'h10
`define VBC_DWELL_AUTO0 12'h020
`define VBC_DWELL_AUTO1 12'h040
`define VBC_DWELL_AUTO2 12'h070
`define VBC_DWELL_AUTO3 12'h090

`endif

/* src/vbc_pkg.sv */
// Types shared by the band calibration block
package vbc_pkg;

  // Band index over the VCO's 64 bands
  typedef logic [5:0] vbc_band_t;

  // Search sequencer states
  typedef enum logic [1:0] {
    VBC_IDLE,
    VBC_DWELL,
    VBC_DECIDE
  } vbc_state_t;

endpackage : vbc_pkg

/* src/vbc_ref_div.sv */
// Reference divider forming the calibration timebase tick
`timescale 1ns/1ps
`default_nettype none
`include "vbc_defs.svh"

module vbc_ref_div (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Control
  input wire logic [1:0] div_code_i,
  // Timebase
  output logic tick_o
);

  logic [2:0] cnt; // Free running reference count
  logic [2:0] next_cnt;
  logic next_tick;

  // ----------------------------------------------------------------------
  // Divide by 2, 4 or 8; code 0 gives no tick at all
  // ----------------------------------------------------------------------
  // Runs on its own count, untouched by any loop divider setting
  always_comb begin
    next_cnt = cnt + 3'h1;
    unique case (div_code_i)
      2'h1: next_tick = (cnt[0] == 1'b1);
      2'h2: next_tick = (cnt[1:0] == 2'h3);
      2'h3: next_tick = (cnt == 3'h7);
      default: next_tick = 1'b0;
    endcase
  end

  // Registers only
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= 3'h0;
      tick_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick_o <= next_tick;
    end
  end

endmodule : vbc_ref_div
`default_nettype wire

/* src/vbc_top.sv */
// VCO band calibration configuration registers and sequencing
//
// Operation
// - Mode code 4 manual; 5 to 7 reserved
// - Auto codes 0-3 match reference frequency ranges
// - Timebase is reference divided by 2/4/8
// - Calibration divider independent of loop dividers
// - Scale in word seven 21:10, adjust bit 4
// - Adjust bit only manual above 40 MHz
// - Linear search steps bands one at a time
// - Mixed search halves first, then linear finish
`timescale 1ns/1ps
`default_nettype none
`include "vbc_defs.svh"

module vbc_top (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // VCO band comparator
  input wire logic vco_slow_i,
  // Calibration results and settings
  output vbc_pkg::vbc_band_t band_o,
  output logic cal_busy_o,
  output logic cal_done_o,
  output logic [3:0] vco_bias_o,
  output logic [15:0] freq_word_o
);

  // ----------------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------------
  logic [2:0] ref_mode_select, next_ref_mode_select; // Reference mode code
  logic [3:0] vco_bias_select, next_vco_bias_select; // Phase noise bias
  logic [11:0] manual_ref_scale, next_manual_ref_scale; // Manual scale
  logic manual_ref_adjust, next_manual_ref_adjust; // Manual timing adjust
  logic [1:0] cal_ref_divider, next_cal_ref_divider; // Timebase divider
  logic [1:0] search_method, next_search_method; // Linear or mixed
  logic [31:0] fixed_word9, next_fixed_word9; // Fixed content word
  logic [31:0] fixed_word12, next_fixed_word12; // Fixed content word

  // Outputs, status and strobes
  logic [15:0] next_freq_word;
  logic done_flag, next_done_flag; // Sticky completion
  logic cfg_error, next_cfg_error; // Last start refused
  logic cal_start, next_cal_start; // One cycle start to the search
  logic [31:0] next_rdata;

  // ----------------------------------------------------------------------
  // Derived control
  // ----------------------------------------------------------------------
  // Legality of the stored codes
  logic mode_ok; // Mode code selects something
  logic div_ok; // Divider code not reserved
  logic method_ok; // Search code not reserved

  // Trial timing
  logic [11:0] dwell; // Ticks per search trial
  logic [12:0] scale_adj; // Manual scale with adjust applied

  // Engine handshake
  logic tick; // Calibration timebase
  logic srch_busy;
  logic srch_done;
  logic freq_wr; // Frequency load strobe

  // Reserved mode codes select nothing and block a start
  assign mode_ok = (ref_mode_select <= `VBC_MODE_MANUAL);
  assign div_ok = (cal_ref_divider != 2'h0);

  // Reserved search codes are refused rather than guessed at
  assign method_ok = (search_method == `VBC_METH_LINEAR) ||
                     (search_method == `VBC_METH_MIXED);

  // Only a frequency write starts a search
  assign freq_wr = wr_i && (addr_i == `VBC_ADDR_FREQ);

  // ----------------------------------------------------------------------
  // Trial length from the reference mode
  // ----------------------------------------------------------------------
  // Adjust bit stretches each manual trial by half again; a longer
  // trial trades lock time for margin on fast references
  always_comb begin
    // Manual scale, optionally stretched
    scale_adj = {1'b0, manual_ref_scale};
    if (manual_ref_adjust) begin
      scale_adj = {1'b0, manual_ref_scale} + {2'b00, manual_ref_scale[11:1]};
    end

    // Fixed lengths in the automatic modes
    unique case (ref_mode_select)
      3'h0: dwell = `VBC_DWELL_AUTO0;
      3'h1: dwell = `VBC_DWELL_AUTO1;
      3'h2: dwell = `VBC_DWELL_AUTO2;
      3'h3: dwell = `VBC_DWELL_AUTO3;
      3'h4: begin
        // Manual mode uses software scale; saturate, never zero
        if (scale_adj[12]) begin
          dwell = 12'hfff;
        end else if (scale_adj[11:0] == 12'h000) begin
          dwell = 12'h001;
        end else begin
          dwell = scale_adj[11:0];
        end
      end
      // Codes 5 to 7
      default: dwell = 12'h001; // Reserved, start is refused anyway
    endcase
  end

  // ----------------------------------------------------------------------
  // Register writes and calibration start
  // ----------------------------------------------------------------------
  always_comb begin
    next_ref_mode_select = ref_mode_select;
    next_vco_bias_select = vco_bias_select;
    next_manual_ref_scale = manual_ref_scale;
    next_manual_ref_adjust = manual_ref_adjust;
    next_cal_ref_divider = cal_ref_divider;
    next_search_method = search_method;
    next_fixed_word9 = fixed_word9;
    next_fixed_word12 = fixed_word12;
    // Outputs and status hold unless told
    next_freq_word = freq_word_o;
    next_cfg_error = cfg_error;
    next_cal_start = 1'b0;
    next_done_flag = done_flag;

    // Stores follow the strobe
    if (wr_i) begin
      unique case (addr_i)
        `VBC_ADDR_FREQ: begin
          // Low half only; upper bits ignored
          next_freq_word = wdata_i[`VBC_FREQ_MSB:0];
        end
        `VBC_ADDR_W6: begin
          // Bias code is stored as given; software owns its choice
          next_ref_mode_select = wdata_i[`VBC_MODE_MSB:`VBC_MODE_LSB];
          next_vco_bias_select = wdata_i[`VBC_BIAS_MSB:`VBC_BIAS_LSB];
        end
        `VBC_ADDR_W7: begin
          // Scale, adjust and divider share a word
          next_manual_ref_scale = wdata_i[`VBC_SCALE_MSB:`VBC_SCALE_LSB];
          next_manual_ref_adjust = wdata_i[`VBC_ADJ_BIT];
          next_cal_ref_divider = wdata_i[`VBC_DIV_MSB:`VBC_DIV_LSB];
        end
        `VBC_ADDR_W8: begin
          // Reserved codes kept; refused at start
          next_search_method = wdata_i[`VBC_METH_MSB:`VBC_METH_LSB];
        end
        `VBC_ADDR_W9: begin
          // Kept whole for readback
          next_fixed_word9 = wdata_i;
        end
        `VBC_ADDR_W12: begin
          // Kept whole for readback
          next_fixed_word12 = wdata_i;
        end
        default: begin
          // Unmapped or read-only: write ignored
        end
      endcase
    end

    // A new frequency kicks off calibration if settings are legal
    if (freq_wr) begin
      if (mode_ok && div_ok && method_ok) begin
        next_cal_start = 1'b1;
        next_cfg_error = 1'b0;
        next_done_flag = 1'b0;
      end else begin
        next_cfg_error = 1'b1;
      end
    end

    // Completion sets over any clear in the same cycle
    if (srch_done) begin
      next_done_flag = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Read data, valid the cycle after the strobe only
  // ----------------------------------------------------------------------
  always_comb begin
    // Idle reads return zero
    next_rdata = 32'h0000_0000;
    if (rd_i) begin
      unique case (addr_i)
        `VBC_ADDR_FREQ: next_rdata[`VBC_FREQ_MSB:0] = freq_word_o;
        `VBC_ADDR_STAT: begin
          // Busy covers the start pulse too
          next_rdata[`VBC_ST_BUSY] = srch_busy | cal_start;
          next_rdata[`VBC_ST_DONE] = done_flag;
          next_rdata[`VBC_ST_ERR] = cfg_error;
          next_rdata[`VBC_ST_BAND_MSB:`VBC_ST_BAND_LSB] = band_o;
        end
        `VBC_ADDR_W6: begin
          // Mode and bias
          next_rdata[`VBC_MODE_MSB:`VBC_MODE_LSB] = ref_mode_select;
          next_rdata[`VBC_BIAS_MSB:`VBC_BIAS_LSB] = vco_bias_select;
        end
        `VBC_ADDR_W7: begin
          // Same layout as the write
          next_rdata[`VBC_SCALE_MSB:`VBC_SCALE_LSB] = manual_ref_scale;
          next_rdata[`VBC_ADJ_BIT] = manual_ref_adjust;
          next_rdata[`VBC_DIV_MSB:`VBC_DIV_LSB] = cal_ref_divider;
        end
        `VBC_ADDR_W8: next_rdata[`VBC_METH_MSB:`VBC_METH_LSB] = search_method;
        `VBC_ADDR_W9: next_rdata = fixed_word9;
        `VBC_ADDR_W12: next_rdata = fixed_word12;
        default: next_rdata = 32'h0000_0000; // Unmapped reads zero
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // Settings to power-up values
      ref_mode_select <= `VBC_RST_MODE;
      vco_bias_select <= `VBC_RST_BIAS;
      manual_ref_scale <= `VBC_RST_SCALE;
      manual_ref_adjust <= 1'b0;
      cal_ref_divider <= `VBC_RST_DIV;
      search_method <= `VBC_RST_METH;
      // Fixed words cleared until loaded
      fixed_word9 <= `VBC_RST_FIXED;
      fixed_word12 <= `VBC_RST_FIXED;
      // Outputs, status and strobes idle
      freq_word_o <= `VBC_RST_FREQ;
      cfg_error <= 1'b0;
      cal_start <= 1'b0;
      done_flag <= 1'b0;
      rdata_o <= 32'h0000_0000;
    end else begin
      // Settings
      ref_mode_select <= next_ref_mode_select;
      vco_bias_select <= next_vco_bias_select;
      manual_ref_scale <= next_manual_ref_scale;
      manual_ref_adjust <= next_manual_ref_adjust;
      cal_ref_divider <= next_cal_ref_divider;
      search_method <= next_search_method;
      // Fixed words
      fixed_word9 <= next_fixed_word9;
      fixed_word12 <= next_fixed_word12;
      // Outputs and status
      freq_word_o <= next_freq_word;
      cfg_error <= next_cfg_error;
      cal_start <= next_cal_start;
      done_flag <= next_done_flag;
      rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Timebase and search engine
  // ----------------------------------------------------------------------
  // Divider changes mid calibration take effect at once; software
  // should not touch it while busy
  vbc_ref_div u_div (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .div_code_i(cal_ref_divider),
    .tick_o(tick)
  );

  // A start while busy restarts the search
  vbc_band_search u_search (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .start_i(cal_start),
    .mixed_i(search_method == `VBC_METH_MIXED),
    .dwell_i(dwell),
    .tick_i(tick),
    .vco_slow_i(vco_slow_i),
    .band_o(band_o),
    .busy_o(srch_busy),
    .done_o(srch_done)
  );

  // Settings and results to the analog side
  assign vco_bias_o = vco_bias_select;
  // Busy covers the registered start pulse
  assign cal_busy_o = srch_busy | cal_start;
  assign cal_done_o = srch_done;

endmodule : vbc_top
`default_nettype wire

/* tb/vbc_top_sva.sv */
// Port checks of the band calibration block
`timescale 1ns/1ps
`default_nettype none

module vbc_top_sva (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  // Calibration
  input wire logic vco_slow_i,
  input wire vbc_pkg::vbc_band_t band_o,
  input wire logic cal_busy_o,
  input wire logic cal_done_o,
  input wire logic [15:0] freq_word_o
);
  default clocking dc @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  // ------
  // Shadow settings
  // ------
  logic [2:0] mode; // Reference mode
  logic [1:0] div; // Divider code
  logic [1:0] meth; // Search method
  logic [12:0] man; // Manual trial length
  logic [5:0] band_q; // Band one cycle back
  logic [15:0] gap; // Cycles since load or step
  logic [15:0] dw; // Trial length in ticks
  logic [15:0] wd_lo; // Low half of write data
  logic start_w; // Frequency load
  logic cfg_ok; // Settings allow a start
  logic lin; // Linear search chosen
  assign wd_lo = wdata_i[15:0];
  assign start_w = wr_i && addr_i == 4'h0;
  assign cfg_ok = mode <= 3'h4 && div != 2'h0 && (meth == 2'h1 || meth == 2'h2);
  assign lin = meth == 2'h1;
  // Trial length per mode; manual is clamped to 1..4095
  always_comb begin
    case (mode)
      3'h0: dw = 16'h0020;
      3'h1: dw = 16'h0040;
      3'h2: dw = 16'h0070;
      3'h3: dw = 16'h0090;
      default: dw = (man > 13'h0fff) ? 16'h0fff : (man == 13'h0) ? 16'h0001 : {3'h0, man};
    endcase
  end
  // Follow the writes; gap saturates so a long idle never wraps
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode <= 3'h0;
      div <= 2'h1;
      meth <= 2'h1;
      man <= 13'h0;
      band_q <= 6'h20;
      gap <= 16'h0;
    end else begin
      band_q <= band_o;
      gap <= (start_w || band_o != band_q) ? 16'h0 : gap + {15'h0, gap != 16'hffff};
      if (wr_i && addr_i == 4'h6) begin
        mode <= wdata_i[2:0];
      end
      if (wr_i && addr_i == 4'h7) begin
        div <= wdata_i[1:0];
        man <= {1'b0, wdata_i[21:10]} + (wdata_i[4] ? {2'h0, wdata_i[21:11]} : 13'h0);
      end
      if (wr_i && addr_i == 4'h8) begin
        meth <= wdata_i[1:0];
      end
    end
  end
  // ------
  // Properties
  // ------
  sequence s_load_ok;
    start_w && cfg_ok;
  endsequence
  sequence s_load_bad;
    start_w && !cal_busy_o && !cfg_ok;
  endsequence
  sequence s_lin_move;
    lin && cal_busy_o && band_o != band_q;
  endsequence
  chk_load_busy: assert property (s_load_ok |=> cal_busy_o [*2])
    else $error("busy not raised by a load");
  chk_load_word: assert property (start_w |=> freq_word_o == $past(wd_lo))
    else $error("frequency word not taken");
  chk_mode_refuse: assert property (s_load_bad ##0 mode > 3'h4 |=> !cal_busy_o [*4])
    else $error("reserved mode started a search");
  chk_div_refuse: assert property (s_load_bad ##0 div == 2'h0 |=> !cal_busy_o [*4])
    else $error("reserved divider started a search");
  chk_lin_unit: assert property (s_lin_move |-> band_o == band_q + 6'h01 || band_o == band_q - 6'h01)
    else $error("linear search skipped a band");
  chk_lin_dir: assert property (s_lin_move |-> $past(vco_slow_i) == (band_o == band_q + 6'h01))
    else $error("linear step against comparator");
  chk_mixed_mid: assert property (s_load_ok ##0 meth == 2'h2 |-> ##[1:3] band_o == 6'h20)
    else $error("mixed search not started mid range");
  chk_trial_len: assert property (s_lin_move |-> gap + (16'h0002 << div) >= (dw << div))
    else $error("trial shorter than timebase allows");
  chk_done_pulse: assert property (cal_done_o |=> !cal_done_o)
    else $error("done longer than one cycle");
endmodule : vbc_top_sva

bind vbc_top vbc_top_sva vbc_top_sva_inst (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .vco_slow_i(vco_slow_i), .band_o(band_o), .cal_busy_o(cal_busy_o),
  .cal_done_o(cal_done_o), .freq_word_o(freq_word_o)
);

`default_nettype wire

/* tb/vbc_top_tb_top.sv */
// Self-checking bench for the band calibration block
`timescale 1ns/1ps
`default_nettype none

module vbc_top_tb_top;
  // ------
  // Signals
  // ------
  logic ref_clk_i = 1'b0; // 100 MHz clock
  logic resetn_i = 1'b0; // Reset, active low
  logic [3:0] addr_i = 4'h0; // Word address
  logic [31:0] wdata_i = 32'h0; // Write data
  logic wr_i = 1'b0; // Write strobe
  logic rd_i = 1'b0; // Read strobe
  logic [31:0] rdata_o; // Read data
  logic vco_slow_i; // Comparator from the model
  vbc_pkg::vbc_band_t band_o; // Band under trial
  vbc_pkg::vbc_band_t target = 6'h20; // Band the model accepts
  logic cal_busy_o; // Search running
  logic cal_done_o; // Search finished
  logic [3:0] vco_bias_o; // Bias setting
  logic [15:0] freq_word_o; // Loaded frequency word
  logic [5:0] cur = 6'h20; // Band the bench expects
  int num_errors = 0;
  int n_checks = 0;

  vbc_top vbc_top_inst (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .vco_slow_i(vco_slow_i),
    .band_o(band_o), .cal_busy_o(cal_busy_o), .cal_done_o(cal_done_o),
    .vco_bias_o(vco_bias_o), .freq_word_o(freq_word_o)
  );
  vbc_vco_model vbc_vco_model_inst (.band_i(band_o), .target_i(target), .vco_slow_o(vco_slow_i));

  // Free-running clock
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // ------
  // Tasks
  // ------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  // One-cycle read; data only stands in the following cycle
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string name);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    check(name, rdata_o, exp);
    @(negedge ref_clk_i);
    check("rdata idle", rdata_o, 32'h0);
  endtask : rd

  // Band the search must end on, worked out step by step
  function automatic logic [5:0] exp_band(input logic [5:0] b0, input logic [5:0] t,
                                          input logic mixed);
    logic [5:0] b;
    logic [5:0] s;
    int prev;
    int dir;
    b = mixed ? 6'h20 : b0;
    prev = 0;
    if (mixed) begin
      for (s = 6'h10; s >= 6'h02; s = s >> 1) begin
        b = (b < t) ? b + s : b - s;
      end
    end
    for (int k = 0; k < 70; k++) begin
      dir = (b < t) ? 1 : -1;
      if ((prev != 0 && dir != prev) || (dir == 1 && b == 6'h3f) || (dir == -1 && b == 6'h00)) break;
      b = b + 6'(dir);
      prev = dir;
    end
    return b;
  endfunction : exp_band

  // Load a frequency and follow the search to its end; bounded wait
  task automatic cal(input logic [5:0] tgt, input logic mixed);
    logic [5:0] exp;
    int i;
    exp = exp_band(cur, tgt, mixed);
    target = tgt;
    wr(4'h0, {16'hffff, 10'h155, tgt});
    @(negedge ref_clk_i);
    check("busy", cal_busy_o, 32'h1);
    for (i = 0; i < 40000 && cal_done_o !== 1'b1; i++) begin
      @(negedge ref_clk_i);
    end
    if (i == 40000) begin
      num_errors++;
      finish_test();
    end
    check("band", band_o, exp);
    check("freq", freq_word_o, {16'h0, 10'h155, tgt});
    cur = exp;
    rd(4'h1, {18'h0, exp, 8'h02}, "stat");
  endtask : cal

  // A bad setting must leave the search idle and flag the error
  task automatic refuse(input logic [3:0] a, input logic [31:0] d);
    wr(a, d);
    wr(4'h0, 32'h0000_1000);
    @(negedge ref_clk_i);
    check("busy", cal_busy_o, 32'h0);
    rd(4'h1, {18'h0, cur, 8'h04}, "stat");
  endtask : refuse

  // ------
  // Main sequence
  // ------
  initial begin
    repeat (10) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    check("bias", vco_bias_o, 32'h8);
    check("band", band_o, 32'h20);
    rd(4'h7, 32'h1, "w7");
    rd(4'h8, 32'h1, "w8");
    rd(4'h2, 32'h0, "unmapped");
    wr(4'h7, 32'hffff_ffff);
    rd(4'h7, 32'h003f_fc13, "w7");
    wr(4'h6, 32'hffff_ffff);
    rd(4'h6, 32'hf7, "w6");
    check("bias", vco_bias_o, 32'hf);
    wr(4'h1, 32'hffff_ffff);
    rd(4'h1, 32'h2000, "stat");
    for (int a = 9; a < 13; a += 3) begin
      wr(a[3:0], 32'h5a5a_0f0f + a);
      rd(a[3:0], 32'h5a5a_0f0f + a, "fixed");
    end
    // Reserved mode, divider and method codes
    for (int m = 5; m < 8; m++) begin
      refuse(4'h6, {24'h0, 4'h8, 1'b0, m[2:0]});
    end
    wr(4'h6, 32'h80);
    refuse(4'h7, 32'h0);
    wr(4'h7, 32'h1);
    refuse(4'h8, 32'h0);
    refuse(4'h8, 32'h3);
    wr(4'h8, 32'h1);
    // Linear search in each automatic mode, both directions
    for (int m = 0; m < 4; m++) begin
      wr(4'h6, {24'h0, 4'h8, 1'b0, m[2:0]});
      wr(4'h7, {30'h0, 2'(m % 3 + 1)});
      cal(m[0] ? cur - 6'h3 : cur + 6'h3, 1'b0);
    end
    // Mixed search out to both edges of the band range
    wr(4'h8, 32'h2);
    cal(6'h3f, 1'b1);
    cal(6'h00, 1'b1);
    // Manual mode with the adjust bit set
    wr(4'h8, 32'h1);
    wr(4'h6, 32'h84);
    wr(4'h7, 32'h0000_4011);
    cal(cur + 6'h2, 1'b0);
    finish_test();
  end
endmodule : vbc_top_tb_top

`default_nettype wire

/* tb/vbc_vco_model.sv */
// Comparator model of the VCO seen by the band search
`timescale 1ns/1ps
`default_nettype none

module vbc_vco_model (
  // Band under trial and the band that fits the target
  input wire vbc_pkg::vbc_band_t band_i,
  input wire vbc_pkg::vbc_band_t target_i,
  // Comparator output
  output logic vco_slow_o
);
  // Below the fitting band the VCO runs slow; held steady for a whole trial
  assign vco_slow_o = band_i < target_i;
endmodule : vbc_vco_model

`default_nettype wire
